/* File: verilog/lichg_ctrl.sv */
// lichg_ctrl: charge phase sequencer and pass-transistor gating
// assumes register bytes are held stable by the I2C block; comparators are async
//
// Behaviour
// - input outside its OV/UV window turns the input pass transistor off at once.
// - input must stay good for 200 us before the system path is enabled.
// - input or battery above lockout makes I2C ready and loads register defaults.
// - input path off kills input transistor; charge inhibit stops charging only.
// - system setpoint comes from bits 3:0 of offset 0x07.
// - below pre-charge threshold, charge in pre-charge with current from 0x03[3:0].
// - pre-charge not finished after one hour stops the cycle with timeout fault.
// - above pre-charge threshold, fast charge with current from 0x02[5:0].
// - at target voltage from 0x04[7:2], move from constant current to constant voltage.
// - with 0x05[4] set, end current starts 3.2 s timer; expiry reports done when 0x05[0] is clear.
// - end-current threshold comes from 0x03[3:0], shared with pre-charge current.
// - timer-only bit 0x05[0] clear stops charging at end; set keeps CV charging.
// - termination disabled ignores end current, keeps CV and charging status.
// - new cycle on input power cycle, charge enable, or auto-recharge.
// - new cycle needs no thermistor, safety timer, battery OV fault, nor inhibit.
// - after termination, battery below recharge level with good input restarts charging.
// - auto-recharge only when termination enabled and timer-only bit clear.
// - battery over-voltage suspends charging immediately and raises a fault.
// - recharge comparator must be deglitched 200 ms before triggering.
// - charge inhibit is bit 3 of 0x01; clearing it enables charging.
// - recharge offset select is bit 0 of 0x04; 1 picks 200 mV.
`timescale 1ns/10ps
`default_nettype none
module lichg_ctrl
  import lichg_pkg::*;
#(
  parameter logic [LICHG_CNT_W-1:0] PRE_CYC  = LICHG_CNT_W'(LICHG_PRE_CYC),
  parameter logic [LICHG_CNT_W-1:0] TERM_CYC = LICHG_CNT_W'(LICHG_TERM_CYC),
  parameter logic [LICHG_CNT_W-1:0] RECH_CYC = LICHG_CNT_W'(LICHG_RECH_CYC)
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // register bytes
  input  wire logic [7:0] ctrl_byte_in,
  input  wire logic [7:0] fast_byte_in,
  input  wire logic [7:0] pre_end_byte_in,
  input  wire logic [7:0] cv_byte_in,
  input  wire logic [7:0] tim_cfg_byte_in,
  input  wire logic [7:0] sys_byte_in,
  input  wire logic       input_path_off_in,
  // analog comparators and fault flags
  input  wire logic [9:0] cmp_in,
  input  wire logic       safety_fault_in,
  // transistor gates and setpoints
  output logic            input_pass_fet_out,
  output logic            cell_charge_en_out,
  output logic            cell_discharge_en_out,
  output logic [5:0]      charge_current_out,
  output logic [3:0]      end_current_threshold_out,
  output logic [5:0]      cv_target_voltage_out,
  output logic            recharge_offset_sel_out,
  output logic [3:0]      sys_setpoint_out,
  // status
  output logic            i2c_ready_out,
  output logic            load_defaults_out,
  output logic [2:0]      status_out,
  output logic            timeout_fault_out,
  output logic            overvoltage_guard_out
);
  // three-stage synchronisers, change taken when stages two and three agree
  // a lone stage-two glitch never agrees with stage three, so it is dropped
  logic [LICHG_N_CMP-1:0] s1;
  logic [LICHG_N_CMP-1:0] s2;
  logic [LICHG_N_CMP-1:0] s3;
  logic [LICHG_N_CMP-1:0] cmp;
  logic [LICHG_N_CMP-1:0] next_cmp;
  always_comb begin
    next_cmp = cmp;
    for (int i = 0; i < LICHG_N_CMP; i++) begin
      if (s2[i] == s3[i]) begin
        next_cmp[i] = s3[i];
      end
    end
  end
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1  <= LICHG_CMP_RST;
      s2  <= LICHG_CMP_RST;
      s3  <= LICHG_CMP_RST;
      cmp <= LICHG_CMP_RST;
    end else begin
      s1  <= cmp_in;
      s2  <= s1;
      s3  <= s2;
      cmp <= next_cmp;
    end
  end

  function automatic logic [LICHG_CNT_W-1:0] bump(input logic [LICHG_CNT_W-1:0] c,
                                                 input logic [LICHG_CNT_W-1:0] lim);
    bump = (c < lim) ? c + LICHG_CNT_W'(1) : c;
  endfunction : bump

  // a new cycle opens in pre-charge for a deep cell, else in fast charge
  function automatic lichg_state_e entry_phase(input logic below_pre);
    entry_phase = below_pre ? LICHG_PRE : LICHG_FAST;
  endfunction : entry_phase

  // software-visible phase code
  function automatic logic [2:0] status_code(input lichg_state_e s);
    case (s)
      LICHG_PRE:   status_code = LICHG_ST_PRE;
      LICHG_FAST:  status_code = LICHG_ST_FAST;
      LICHG_CV:    status_code = LICHG_ST_CV;
      LICHG_DONE:  status_code = LICHG_ST_DONE;
      LICHG_FAULT: status_code = LICHG_ST_FAULT;
      default:     status_code = LICHG_ST_IDLE;
    endcase
  endfunction : status_code

  // field decode
  // register bytes are same-clock levels and need no synchroniser
  logic charge_inhibit;
  logic term_en;
  logic end_timer_only;
  logic in_window;
  logic supply_up;
  logic rech_ok;
  assign charge_inhibit = ctrl_byte_in[LICHG_INHIBIT_BIT];
  assign term_en        = tim_cfg_byte_in[LICHG_TERM_EN_BIT];
  assign end_timer_only = tim_cfg_byte_in[LICHG_TMR_ONLY_BIT];
  assign in_window      = ~cmp[LICHG_C_IN_OV] & ~cmp[LICHG_C_IN_UV];
  assign supply_up      = cmp[LICHG_C_IN_UP] | cmp[LICHG_C_BAT_UP];
  assign rech_ok        = term_en & ~end_timer_only;

  // state
  lichg_state_e           state;
  lichg_state_e           next_state;
  logic [LICHG_CNT_W-1:0] qual_cnt;
  logic [LICHG_CNT_W-1:0] next_qual_cnt;
  logic [LICHG_CNT_W-1:0] ph_cnt;
  logic [LICHG_CNT_W-1:0] next_ph_cnt;
  logic [LICHG_CNT_W-1:0] rech_cnt;
  logic [LICHG_CNT_W-1:0] next_rech_cnt;
  logic                   in_good;
  logic                   next_in_good;
  logic                   inhibit_d;
  logic                   supply_d;
  logic                   tmo;
  logic                   next_tmo;
  logic                   start_req;
  logic                   can_start;

  always_comb begin
    // any loss of the window restarts qualification from zero
    next_qual_cnt = '0;
    next_in_good  = 1'b0;
    if (in_window) begin
      next_qual_cnt = bump(qual_cnt, LICHG_CNT_W'(LICHG_QUAL_CYC));
      next_in_good  = in_good | (qual_cnt == LICHG_CNT_W'(LICHG_QUAL_CYC));
    end
    // power cycle or 1-to-0 inhibit write starts a cycle
    start_req = (next_in_good & ~in_good) | (inhibit_d & ~charge_inhibit);
    // this edge's qualification counts, so a power-up start is not lost
    can_start = next_in_good & ~cmp[LICHG_C_NTC] & ~safety_fault_in & ~cmp[LICHG_C_BAT_OV]
                & ~charge_inhibit;
    next_state    = state;
    next_ph_cnt   = ph_cnt;
    next_rech_cnt = '0;
    next_tmo      = tmo;
    case (state)
      LICHG_IDLE, LICHG_FAULT: begin
        // held until a start request below
        next_state = state;
      end
      LICHG_PRE: begin
        // saturating count, so the timeout compare stays true once reached
        next_ph_cnt = bump(ph_cnt, PRE_CYC);
        if (!cmp[LICHG_C_BELOW_P]) begin
          next_ph_cnt = '0;
          next_state  = LICHG_FAST;
        end else if (ph_cnt == PRE_CYC) begin
          next_tmo   = 1'b1;
          next_state = LICHG_FAULT;
        end
      end
      LICHG_FAST: begin
        if (cmp[LICHG_C_AT_TGT]) begin
          next_ph_cnt = '0;
          next_state  = LICHG_CV;
        end
      end
      LICHG_CV: begin
        // end timer restarts whenever the current rises above the threshold
        next_ph_cnt = '0;
        if (term_en && cmp[LICHG_C_END_I]) begin
          next_ph_cnt = bump(ph_cnt, TERM_CYC);
          if (ph_cnt == TERM_CYC && !end_timer_only) begin
            next_state = LICHG_DONE;
          end
        end
      end
      LICHG_DONE: begin
        // recharge level must hold for the whole deglitch span
        if (cmp[LICHG_C_RECH] && in_good && rech_ok) begin
          next_rech_cnt = bump(rech_cnt, RECH_CYC);
        end
        if (rech_cnt == RECH_CYC && can_start) begin
          next_rech_cnt = '0;
          next_ph_cnt   = '0;
          next_state    = entry_phase(cmp[LICHG_C_BELOW_P]);
        end
      end
      default: next_state = LICHG_IDLE;
    endcase
    // a start request restarts the cycle from any phase
    if (start_req && can_start) begin
      next_tmo      = 1'b0;
      next_ph_cnt   = '0;
      next_rech_cnt = '0;
      next_state    = entry_phase(cmp[LICHG_C_BELOW_P]);
    end
    // losing the input drops to idle; a fault stays for the host to see
    if (!next_in_good) begin
      next_state = (next_state == LICHG_FAULT) ? LICHG_FAULT : LICHG_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state     <= LICHG_IDLE;
      qual_cnt  <= '0;
      ph_cnt    <= '0;
      rech_cnt  <= '0;
      in_good   <= 1'b0;
      inhibit_d <= 1'b0;
      supply_d  <= 1'b0;
      tmo       <= 1'b0;
    end else begin
      state     <= next_state;
      qual_cnt  <= next_qual_cnt;
      ph_cnt    <= next_ph_cnt;
      rech_cnt  <= next_rech_cnt;
      in_good   <= next_in_good;
      inhibit_d <= charge_inhibit;
      supply_d  <= supply_up;
      tmo       <= next_tmo;
    end
  end

  // registered outputs
  logic       n_in_fet;
  logic       n_chg;
  logic       n_ready;
  logic       n_load;
  logic       n_bov;
  logic [5:0] n_cur;
  logic [2:0] n_st;
  logic       charging;
  always_comb begin
    charging = (next_state == LICHG_PRE) | (next_state == LICHG_FAST) | (next_state == LICHG_CV);
    n_in_fet = next_in_good & ~input_path_off_in;
    // charge gate drops at once on inhibit or cell over-voltage, state is kept
    n_chg    = charging & ~charge_inhibit & ~cmp[LICHG_C_BAT_OV];
    n_bov    = cmp[LICHG_C_BAT_OV];
    n_ready  = supply_up;
    // one-cycle pulse reloads the register defaults
    n_load   = supply_up & ~supply_d;
    n_cur    = (next_state == LICHG_PRE) ? {2'h0, pre_end_byte_in[LICHG_PRE_MSB:0]}
                                         : fast_byte_in[LICHG_FAST_MSB:0];
    n_st     = status_code(next_state);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      input_pass_fet_out        <= 1'b0;
      cell_charge_en_out        <= 1'b0;
      cell_discharge_en_out     <= 1'b0;
      charge_current_out        <= 6'h00;
      end_current_threshold_out <= 4'h0;
      cv_target_voltage_out     <= 6'h00;
      recharge_offset_sel_out   <= 1'b0;
      sys_setpoint_out          <= 4'h0;
      i2c_ready_out             <= 1'b0;
      load_defaults_out         <= 1'b0;
      status_out                <= LICHG_ST_IDLE;
      timeout_fault_out         <= 1'b0;
      overvoltage_guard_out     <= 1'b0;
    end else begin
      input_pass_fet_out        <= n_in_fet;
      cell_charge_en_out        <= n_chg;
      // discharge path is never blocked here
      cell_discharge_en_out     <= 1'b1;
      charge_current_out        <= n_cur;
      end_current_threshold_out <= pre_end_byte_in[LICHG_PRE_MSB:0];
      cv_target_voltage_out     <= cv_byte_in[LICHG_CV_MSB:LICHG_CV_LSB];
      recharge_offset_sel_out   <= cv_byte_in[LICHG_RECH_SEL_BIT];
      sys_setpoint_out          <= sys_byte_in[LICHG_SYS_MSB:0];
      i2c_ready_out             <= n_ready;
      load_defaults_out         <= n_load;
      status_out                <= n_st;
      timeout_fault_out         <= next_tmo;
      overvoltage_guard_out     <= n_bov;
    end
  end
endmodule : lichg_ctrl
`default_nettype wire

/* File: verilog/lichg_pkg.sv */
// lichg_pkg: constants for the single-cell charge sequencer
// assumes a 20 MHz system clock shared by every timer
package lichg_pkg;
  // register offsets and field positions
  localparam logic [7:0] LICHG_OFS_CTRL    = 8'h01;
  localparam logic [7:0] LICHG_OFS_FAST    = 8'h02;
  localparam logic [7:0] LICHG_OFS_PREEND  = 8'h03;
  localparam logic [7:0] LICHG_OFS_CV      = 8'h04;
  localparam logic [7:0] LICHG_OFS_TIMCFG  = 8'h05;
  localparam logic [7:0] LICHG_OFS_SYS     = 8'h07;
  localparam int LICHG_INHIBIT_BIT  = 3;
  localparam int LICHG_FAST_MSB     = 5;
  localparam int LICHG_PRE_MSB      = 3;
  localparam int LICHG_CV_MSB       = 7;
  localparam int LICHG_CV_LSB       = 2;
  localparam int LICHG_RECH_SEL_BIT = 0;
  localparam int LICHG_TERM_EN_BIT  = 4;
  localparam int LICHG_TMR_ONLY_BIT = 0;
  localparam int LICHG_SYS_MSB      = 3;
  // timing
  localparam longint LICHG_CLK_HZ       = 20000000;
  localparam longint LICHG_QUAL_TIME_US = 200;
  localparam longint LICHG_TERM_TIME_MS = 3200;
  localparam longint LICHG_RECH_TIME_MS = 200;
  localparam longint LICHG_PRE_TIME_HR  = 1;
  localparam longint LICHG_QUAL_CYC = LICHG_QUAL_TIME_US * LICHG_CLK_HZ / 1000000;
  localparam longint LICHG_TERM_CYC = LICHG_TERM_TIME_MS * LICHG_CLK_HZ / 1000;
  localparam longint LICHG_RECH_CYC = LICHG_RECH_TIME_MS * LICHG_CLK_HZ / 1000;
  localparam longint LICHG_PRE_CYC  = LICHG_PRE_TIME_HR * 3600 * LICHG_CLK_HZ;
  localparam int     LICHG_CNT_W    = 40;
  // comparator vector positions
  localparam int LICHG_N_CMP     = 10;
  localparam int LICHG_C_IN_OV   = 0;
  localparam int LICHG_C_IN_UV   = 1;
  localparam int LICHG_C_IN_UP   = 2;
  localparam int LICHG_C_BAT_UP  = 3;
  localparam int LICHG_C_BELOW_P = 4;
  localparam int LICHG_C_AT_TGT  = 5;
  localparam int LICHG_C_END_I   = 6;
  localparam int LICHG_C_RECH    = 7;
  localparam int LICHG_C_BAT_OV  = 8;
  localparam int LICHG_C_NTC     = 9;
  localparam logic [LICHG_N_CMP-1:0] LICHG_CMP_RST = 10'h0;
  typedef enum {LICHG_IDLE, LICHG_PRE, LICHG_FAST, LICHG_CV, LICHG_DONE, LICHG_FAULT} lichg_state_e;
  // status codes
  localparam logic [2:0] LICHG_ST_IDLE  = 3'h0;
  localparam logic [2:0] LICHG_ST_PRE   = 3'h1;
  localparam logic [2:0] LICHG_ST_FAST  = 3'h2;
  localparam logic [2:0] LICHG_ST_CV    = 3'h3;
  localparam logic [2:0] LICHG_ST_DONE  = 3'h4;
  localparam logic [2:0] LICHG_ST_FAULT = 3'h7;
endpackage : lichg_pkg

/* File: tb/lichg_src_model.sv */
// lichg_src_model: input source and cell as seen through the comparators
// level codes come from tb; outputs change with no regard to the clock
`timescale 1ns/10ps
`default_nettype none
module lichg_src_model
  import lichg_pkg::*;
(
  // source and cell condition
  input  wire logic       in_on_in,
  input  wire logic       in_ov_in,
  input  wire logic [2:0] batt_lvl_in,
  // comparator flags
  output logic [9:0]      cmp_out
);
  // lvl: 0 deep, 1 mid, 2 full, 3 tapered, 4 sagged, 5 over
  always_comb begin
    cmp_out                  = 10'h000;
    cmp_out[LICHG_C_IN_OV]   = in_ov_in;
    cmp_out[LICHG_C_IN_UV]   = !in_on_in;
    cmp_out[LICHG_C_IN_UP]   = in_on_in;
    cmp_out[LICHG_C_BAT_UP]  = 1'h1;
    cmp_out[LICHG_C_BELOW_P] = batt_lvl_in == 3'h0;
    cmp_out[LICHG_C_AT_TGT]  = batt_lvl_in inside {3'h2, 3'h3, 3'h5};
    cmp_out[LICHG_C_END_I]   = batt_lvl_in == 3'h3;
    cmp_out[LICHG_C_RECH]    = batt_lvl_in == 3'h4;
    cmp_out[LICHG_C_BAT_OV]  = batt_lvl_in == 3'h5;
  end
endmodule : lichg_src_model
`default_nettype wire

/* File: tb/lichg_checker.sv */
// lichg_checker: port assertions for the charge sequencer
// bound to lichg_ctrl; one clock domain
`timescale 1ns/10ps
`default_nettype none
module lichg_checker
  import lichg_pkg::*;
(
  input wire logic       ref_clk_in, sys_rst_in, input_path_off_in,
  input wire logic [7:0] ctrl_byte_in, fast_byte_in, pre_end_byte_in, sys_byte_in,
  input wire logic [9:0] cmp_in,
  input wire logic       input_pass_fet_out, cell_charge_en_out, cell_discharge_en_out,
  input wire logic       i2c_ready_out, load_defaults_out, timeout_fault_out, overvoltage_guard_out,
  input wire logic [5:0] charge_current_out,
  input wire logic [3:0] sys_setpoint_out,
  input wire logic [2:0] status_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_window_cut: assert property ((cmp_in[0] | cmp_in[1]) [*6] |-> !input_pass_fet_out)
    else $error("input fet on outside window");
  chk_path_off: assert property (input_path_off_in [*2] |-> !input_pass_fet_out)
    else $error("input fet on while path off");
  chk_inhibit_cut: assert property (ctrl_byte_in[LICHG_INHIBIT_BIT] [*3] |-> !cell_charge_en_out)
    else $error("charging while inhibited");
  chk_discharge_on: assert property (!$past(sys_rst_in) |-> cell_discharge_en_out)
    else $error("discharge path blocked");
  chk_ready_up: assert property ((cmp_in[2] | cmp_in[3]) [*6] |-> i2c_ready_out)
    else $error("interface not ready");
  chk_defaults_pulse: assert property (load_defaults_out |=> !load_defaults_out)
    else $error("defaults pulse too long");
  chk_sys_copy: assert property ($stable(sys_byte_in) && !$past(sys_rst_in) |-> sys_setpoint_out == sys_byte_in[3:0])
    else $error("system setpoint mismatch");
  chk_pre_cur: assert property (status_out == LICHG_ST_PRE && $stable(pre_end_byte_in)
    |-> charge_current_out == {2'h0, pre_end_byte_in[3:0]})
    else $error("pre-charge current mismatch");
  chk_fast_cur: assert property (status_out == LICHG_ST_FAST && $stable(fast_byte_in)
    |-> charge_current_out == fast_byte_in[5:0])
    else $error("fast current mismatch");
  chk_batt_ov: assert property (cmp_in[8] [*6] |-> !cell_charge_en_out && overvoltage_guard_out)
    else $error("charging through cell over-voltage");
  chk_timeout_code: assert property ($rose(timeout_fault_out) |-> status_out == LICHG_ST_FAULT)
    else $error("timeout without fault status");
  cover property (status_out == LICHG_ST_DONE);
  cover property (status_out == LICHG_ST_FAULT);
  cover property ($rose(input_pass_fet_out));
endmodule : lichg_checker
`default_nettype wire
bind lichg_ctrl lichg_checker u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .input_path_off_in(input_path_off_in), .ctrl_byte_in(ctrl_byte_in), .fast_byte_in(fast_byte_in),
  .pre_end_byte_in(pre_end_byte_in), .sys_byte_in(sys_byte_in), .cmp_in(cmp_in),
  .input_pass_fet_out(input_pass_fet_out), .cell_charge_en_out(cell_charge_en_out),
  .cell_discharge_en_out(cell_discharge_en_out), .i2c_ready_out(i2c_ready_out),
  .load_defaults_out(load_defaults_out), .timeout_fault_out(timeout_fault_out),
  .overvoltage_guard_out(overvoltage_guard_out), .charge_current_out(charge_current_out),
  .sys_setpoint_out(sys_setpoint_out), .status_out(status_out));

/* File: tb/tb.sv */
// tb: sequence tests of the charge sequencer through its ports
// short timers: pre 50, end 20, recharge 10 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lichg_pkg::*;
  logic       clk, rst, path_off, in_on, in_ov, safety, fet, chg, dis, rsel, rdy, ld, tmo, ovg;
  logic [7:0] ctrl, fast, pre, cv, tim, sys;
  logic [2:0] lvl, st;
  logic [9:0] cmp;
  logic [5:0] cur, cvt;
  logic [3:0] endt, ssp;
  int         mismatches, checked, i;
  lichg_src_model u_src (.in_on_in(in_on), .in_ov_in(in_ov), .batt_lvl_in(lvl), .cmp_out(cmp));
  lichg_ctrl #(.PRE_CYC(40'h32), .TERM_CYC(40'h14), .RECH_CYC(40'h0A)) u_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .ctrl_byte_in(ctrl), .fast_byte_in(fast),
    .pre_end_byte_in(pre), .cv_byte_in(cv), .tim_cfg_byte_in(tim), .sys_byte_in(sys),
    .input_path_off_in(path_off), .cmp_in(cmp), .safety_fault_in(safety),
    .input_pass_fet_out(fet), .cell_charge_en_out(chg), .cell_discharge_en_out(dis),
    .charge_current_out(cur), .end_current_threshold_out(endt), .cv_target_voltage_out(cvt),
    .recharge_offset_sel_out(rsel), .sys_setpoint_out(ssp), .i2c_ready_out(rdy),
    .load_defaults_out(ld), .status_out(st), .timeout_fault_out(tmo), .overvoltage_guard_out(ovg));
  initial begin
    clk = 1'h0;
    forever #25 clk = !clk;
  end
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wait_st(input logic [2:0] exp, input int lim);
    for (i = 0; i < lim && st !== exp; i++) @(negedge clk);
    chk(st, exp);
    $display("test phase %0h done", exp);
  endtask : wait_st
  task results;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (12000) @(posedge clk);
    mismatches++;
    results;
  end
  initial begin
    {rst, ctrl, fast, pre, cv, tim, sys} = {1'h1, 8'h08, 8'h2B, 8'h05, 8'hC9, 8'h10, 8'h0A};
    {path_off, in_on, in_ov, safety, lvl} = {1'h0, 1'h1, 1'h0, 1'h0, 3'h0};
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    step(5);
    chk(ld, 8'h01);
    step(3);
    chk(ld, 8'h00);
    chk(rdy, 8'h01);
    chk(dis, 8'h01);
    chk(ssp, 8'h0A);
    chk(endt, 8'h05);
    chk(cvt, 8'h32);
    chk(rsel, 8'h01);
    step(3800);
    chk(fet, 8'h00);
    for (i = 0; i < 400 && fet !== 1'h1; i++) @(negedge clk);
    chk(fet, 8'h01);
    path_off = 1'h1;
    step(2);
    chk(fet, 8'h00);
    path_off = 1'h0;
    ctrl = 8'h00;
    wait_st(LICHG_ST_PRE, 12);
    chk(cur, 8'h05);
    lvl = 3'h1;
    wait_st(LICHG_ST_FAST, 12);
    chk(cur, 8'h2B);
    chk(chg, 8'h01);
    lvl = 3'h2;
    wait_st(LICHG_ST_CV, 12);
    {tim, lvl} = {8'h00, 3'h3};
    step(40);
    chk(st, LICHG_ST_CV);
    tim = 8'h11;
    step(40);
    chk(st, LICHG_ST_CV);
    lvl = 3'h2;
    step(8);
    {tim, lvl} = {8'h10, 3'h3};
    step(23);
    chk(st, LICHG_ST_CV);
    wait_st(LICHG_ST_DONE, 4);
    chk(chg, 8'h00);
    {tim, lvl} = {8'h11, 3'h4};
    step(20);
    chk(st, LICHG_ST_DONE);
    tim = 8'h10;
    step(9);
    chk(st, LICHG_ST_DONE);
    wait_st(LICHG_ST_FAST, 4);
    lvl = 3'h5;
    step(8);
    chk({chg, ovg}, 8'h01);
    lvl = 3'h1;
    ctrl = 8'h08;
    step(8);
    chk({chg, dis}, 8'h01);
    lvl = 3'h0;
    step(8);
    ctrl = 8'h00;
    wait_st(LICHG_ST_PRE, 12);
    step(49);
    chk(st, LICHG_ST_PRE);
    wait_st(LICHG_ST_FAULT, 4);
    chk(tmo, 8'h01);
    {safety, ctrl} = {1'h1, 8'h08};
    step(2);
    ctrl = 8'h00;
    step(8);
    chk(st, LICHG_ST_FAULT);
    {safety, in_ov} = {1'h0, 1'h1};
    step(7);
    chk(fet, 8'h00);
    in_ov = 1'h0;
    wait_st(LICHG_ST_PRE, 4100);
    chk({tmo, fet}, 8'h01);
    results;
  end
endmodule : tb
`default_nettype wire
